//--- core/ictm_core.sv
// Instruction length and cycle timing decoder with arithmetic flag unit
// Operation
// - External-data writes go to on-chip external RAM or flash program store.
// - No off-chip bus exists; external-data moves reach on-chip targets only.
// - Add, add-carry, subtract-borrow with bank register: 1 byte, 1 cycle.
// - Same operations with direct byte: 2 bytes, 2 cycles.
// - Accumulator arithmetic with indirect RAM: 1 byte, 2 cycles.
// - Accumulator arithmetic with immediate: 2 bytes, 2 cycles.
// - AND, OR, XOR of immediate into direct byte: 3 bytes, 3 cycles.
// - Logic of accumulator into direct byte: 2 bytes, 2 cycles.
// - Logic of indirect RAM into accumulator: 1 byte, 2 cycles.
// - Accumulator-only clear, complement, rotate, swap: 1 byte, 1 cycle.
// - Code byte read relative pointer or counter: 1 byte, 3 cycles.
// - Every external-data move, read or write: 1 byte, 3 cycles.
// - Load data pointer with 16-bit constant: 3 bytes, 3 cycles.
// - Push or pop direct byte: 2 bytes, 2 cycles.
// - Move direct byte to direct byte: 3 bytes, 3 cycles.
// - Store accumulator to indirect RAM: 1 byte, 2 cycles.
// - Move bank register to direct byte: 2 bytes, 2 cycles.
// - Exchange low nibble of indirect RAM with accumulator: 1 byte, 2 cycles.
// - Otherwise one clock cycle per program byte, except other one-byte indirect RAM ops 2, multiply 4 and divide 8 cycles; timing counted in clocks.
// - Writes go to flash only while store write-enable is set, else RAM.
module ictm_core #(
  parameter int unsigned OPC_W = ictm_pkg::OPC_W
) (
  input  wire logic             i_sys_clk,   // System clock, 20 MHz
  input  wire logic             i_resetn,    // Async reset, active low
  input  wire logic             i_issue,     // Opcode valid, pulse
  input  wire logic [OPC_W-1:0] i_opcode,    // First byte of instruction
  input  wire logic [7:0]       i_acc,       // Accumulator operand
  input  wire logic [7:0]       i_opnd,      // Second operand
  input  wire logic             i_cy,        // Carry in
  input  wire logic             i_pswe,      // Program store write enable
  output logic                  o_ready,     // Idle, may issue
  output logic                  o_done,      // Instruction retires, pulse
  output logic [3:0]            o_len,       // Program bytes of instruction
  output logic [3:0]            o_cyc,       // Clock cycles of instruction
  output logic                  o_xdata_req, // External-data access, pulse
  output logic                  o_xdata_wr,  // Access is a write
  output logic                  o_xdata_wide,// 16-bit pointer address
  output logic [1:0]            o_xdata_tgt, // Target of access
  output logic [7:0]            o_result,    // Arithmetic result
  output ictm_pkg::ictm_flags_s o_flags      // Carry, aux carry, overflow
);

  if (OPC_W != ictm_pkg::OPC_W) begin : g_bad_opc_w
    $error("ictm_core supports only 8-bit opcodes");
  end

  if (2 ** ictm_pkg::CNT_W <= ictm_pkg::CYC_8) begin : g_bad_cnt_w
    $error("ictm_core cycle counter too narrow for longest instruction");
  end

  typedef struct packed {
    ictm_pkg::ictm_state_e st;
    logic [3:0]            cnt;
    logic                  ready;
    logic                  done;
    logic [3:0]            len;
    logic [3:0]            cyc;
    logic                  xreq;
    logic                  xwr;
    logic                  xwide;
    logic [1:0]            xtgt;
    logic [7:0]            res;
    ictm_pkg::ictm_flags_s fl;
  } ictm_regs_s;

  ictm_regs_s r_q;
  ictm_regs_s r_d;
  ictm_pkg::ictm_dec_s dec;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic       c7;
  logic       sub;

  assign hi = i_opcode[7:4];
  assign lo = i_opcode[3:0];

  // First byte alone sets length and clock count
  always_comb begin
    dec = '{len: ictm_pkg::LEN_1, cyc: ictm_pkg::LEN_1,
            xdata: 1'b0, xwrite: 1'b0, xwide: 1'b0, known: 1'b0};
    if (lo >= ictm_pkg::LO_REG) begin
      dec.known = 1'b1;
      if (hi == ictm_pkg::OP_MOVDR_HI[4:1]
          && i_opcode[7:3] == ictm_pkg::OP_MOVDR_HI) begin
        dec.len = ictm_pkg::LEN_2;
        dec.cyc = ictm_pkg::LEN_2;
      end
    end else if (lo == ictm_pkg::LO_IND || lo == ictm_pkg::LO_IND + 4'h1) begin
      dec.known = 1'b1;
      dec.cyc   = ictm_pkg::LEN_2;
      if (i_opcode == ictm_pkg::OP_MOV_IA0 || i_opcode == ictm_pkg::OP_MOV_IA1
          || i_opcode == ictm_pkg::OP_XCHD0
          || i_opcode == ictm_pkg::OP_XCHD1) begin
        dec.cyc = ictm_pkg::LEN_2;
      end
    end else if (lo == ictm_pkg::LO_DIR && i_opcode != ictm_pkg::OP_MOVDD) begin
      dec.known = 1'b1;
      dec.len   = ictm_pkg::LEN_2;
      dec.cyc   = ictm_pkg::LEN_2;
    end else if (lo == ictm_pkg::LO_IMM && (hi == ictm_pkg::HI_ADD
             || hi == ictm_pkg::HI_ADDC || hi == ictm_pkg::HI_SUBB
             || hi == ictm_pkg::HI_ORL || hi == ictm_pkg::HI_ANL
             || hi == ictm_pkg::HI_XRL)) begin
      dec.known = 1'b1;
      dec.len   = ictm_pkg::LEN_2;
      dec.cyc   = ictm_pkg::LEN_2;
    end else if (lo == ictm_pkg::LO_DIRA && (hi == ictm_pkg::HI_ORL
             || hi == ictm_pkg::HI_ANL || hi == ictm_pkg::HI_XRL)) begin
      dec.known = 1'b1;
      dec.len   = ictm_pkg::LEN_2;
      dec.cyc   = ictm_pkg::LEN_2;
    end else if (lo == ictm_pkg::LO_DIRI && (hi == ictm_pkg::HI_ORL
             || hi == ictm_pkg::HI_ANL || hi == ictm_pkg::HI_XRL)) begin
      dec.known = 1'b1;
      dec.len   = ictm_pkg::LEN_3;
      dec.cyc   = ictm_pkg::LEN_3;
    end else begin
      case (i_opcode)
        ictm_pkg::OP_CLR_A, ictm_pkg::OP_CPL_A, ictm_pkg::OP_RR_A,
        ictm_pkg::OP_RRC_A, ictm_pkg::OP_RL_A, ictm_pkg::OP_RLC_A,
        ictm_pkg::OP_SWAP: begin
          dec.known = 1'b1;
        end
        ictm_pkg::OP_CODE_BYTE_MOVE_D, ictm_pkg::OP_CODE_BYTE_MOVE_P: begin
          dec.known = 1'b1;
          dec.cyc   = ictm_pkg::LEN_3;
        end
        ictm_pkg::OP_XR_I0, ictm_pkg::OP_XR_I1: begin
          dec = '{len: ictm_pkg::LEN_1, cyc: ictm_pkg::LEN_3,
                  xdata: 1'b1, xwrite: 1'b0, xwide: 1'b0, known: 1'b1};
        end
        ictm_pkg::OP_XR_D: begin
          dec = '{len: ictm_pkg::LEN_1, cyc: ictm_pkg::LEN_3,
                  xdata: 1'b1, xwrite: 1'b0, xwide: 1'b1, known: 1'b1};
        end
        ictm_pkg::OP_XW_I0, ictm_pkg::OP_XW_I1: begin
          dec = '{len: ictm_pkg::LEN_1, cyc: ictm_pkg::LEN_3,
                  xdata: 1'b1, xwrite: 1'b1, xwide: 1'b0, known: 1'b1};
        end
        ictm_pkg::OP_XW_D: begin
          dec = '{len: ictm_pkg::LEN_1, cyc: ictm_pkg::LEN_3,
                  xdata: 1'b1, xwrite: 1'b1, xwide: 1'b1, known: 1'b1};
        end
        ictm_pkg::OP_LD_DP, ictm_pkg::OP_MOVDD: begin
          dec.known = 1'b1;
          dec.len   = ictm_pkg::LEN_3;
          dec.cyc   = ictm_pkg::LEN_3;
        end
        ictm_pkg::OP_PUSH, ictm_pkg::OP_POP: begin
          dec.known = 1'b1;
          dec.len   = ictm_pkg::LEN_2;
          dec.cyc   = ictm_pkg::LEN_2;
        end
        ictm_pkg::OP_MUL: begin
          dec.known = 1'b1;
          dec.cyc   = ictm_pkg::CYC_4;
        end
        ictm_pkg::OP_DIV: begin
          dec.known = 1'b1;
          dec.cyc   = ictm_pkg::CYC_8;
        end
        default: begin
          dec.cyc = dec.len;
        end
      endcase
    end

    // Moves whose length the addressing group alone does not give
    case (i_opcode)
      ictm_pkg::OP_MOV_AIMM, ictm_pkg::OP_MOV_IIMM0,
      ictm_pkg::OP_MOV_IIMM1, ictm_pkg::OP_MOV_DI0,
      ictm_pkg::OP_MOV_DI1, ictm_pkg::OP_MOV_ID0,
      ictm_pkg::OP_MOV_ID1: begin
        dec.known = 1'b1;
        dec.len   = ictm_pkg::LEN_2;
        dec.cyc   = ictm_pkg::LEN_2;
      end
      ictm_pkg::OP_MOV_DIMM: begin
        dec.known = 1'b1;
        dec.len   = ictm_pkg::LEN_3;
        dec.cyc   = ictm_pkg::LEN_3;
      end
      ictm_pkg::OP_SPARE: begin
        dec.known = 1'b1;
        dec.len   = ictm_pkg::LEN_1;
        dec.cyc   = ictm_pkg::LEN_1;
      end
      default: begin
      end
    endcase
    // Bank register moves that carry an operand byte
    if (i_opcode[7:3] == ictm_pkg::OP_MOVRI_HI
        || i_opcode[7:3] == ictm_pkg::OP_MOVRD_HI) begin
      dec.len = ictm_pkg::LEN_2;
      dec.cyc = ictm_pkg::LEN_2;
    end
  end

  // Adder shared by add, add-with-carry and subtract-with-borrow
  always_comb begin
    sub  = (hi == ictm_pkg::HI_SUBB);
    sum5 = 5'h00;
    sum7 = 8'h00;
    sum9 = 9'h000;
    c7   = 1'b0;
    if (sub) begin
      sum5 = {1'b0, i_acc[3:0]} - {1'b0, i_opnd[3:0]} - {4'h0, i_cy};
      sum7 = {1'b0, i_acc[6:0]} - {1'b0, i_opnd[6:0]} - {7'h00, i_cy};
      sum9 = {1'b0, i_acc} - {1'b0, i_opnd} - {8'h00, i_cy};
    end else begin
      sum5 = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]}
           + {4'h0, i_cy & (hi == ictm_pkg::HI_ADDC)};
      sum7 = {1'b0, i_acc[6:0]} + {1'b0, i_opnd[6:0]}
           + {7'h00, i_cy & (hi == ictm_pkg::HI_ADDC)};
      sum9 = {1'b0, i_acc} + {1'b0, i_opnd}
           + {8'h00, i_cy & (hi == ictm_pkg::HI_ADDC)};
    end
    c7 = sum7[7];
  end

  // Counter holds clocks left after the first two; zero retires next
  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    r_d.xreq = 1'b0;
    case (r_q.st)
      ictm_pkg::ST_IDLE: begin
        if (i_issue) begin
          r_d.len   = dec.len;
          r_d.cyc   = dec.cyc;
          r_d.xwr   = dec.xwrite;
          r_d.xwide = dec.xwide;
          r_d.xreq  = dec.xdata;
          r_d.xtgt  = ictm_pkg::XT_NONE;
          // Reads stay in RAM: the program store is only written this way
          if (dec.xdata) begin
            r_d.xtgt = (dec.xwrite && i_pswe) ? ictm_pkg::XT_FLASH
                                              : ictm_pkg::XT_RAM;
          end
          if (hi == ictm_pkg::HI_ADD || hi == ictm_pkg::HI_ADDC
              || hi == ictm_pkg::HI_SUBB) begin
            if (lo >= ictm_pkg::LO_IMM) begin
              r_d.res   = sum9[7:0];
              r_d.fl.cy = sum9[8];
              r_d.fl.ac = sum5[4];
              r_d.fl.ov = sum9[8] ^ c7;
            end
          end
          if (dec.cyc == ictm_pkg::LEN_1) begin
            r_d.done  = 1'b1;
          end else begin
            r_d.st    = ictm_pkg::ST_BUSY;
            r_d.ready = 1'b0;
            r_d.cnt   = dec.cyc - ictm_pkg::LEN_2;
          end
        end
      end
      ictm_pkg::ST_BUSY: begin
        if (r_q.cnt == 4'h0) begin
          r_d.st    = ictm_pkg::ST_IDLE;
          r_d.ready = 1'b1;
          r_d.done  = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      default: begin
        r_d.st    = ictm_pkg::ST_IDLE;
        r_d.ready = 1'b1;
      end
    endcase
  end

  // Reset leaves the core idle so an issue is taken at the first edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_q       <= '0;
      r_q.st    <= ictm_pkg::ST_IDLE;
      r_q.ready <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Every output comes straight from the state register
  assign o_ready      = r_q.ready;
  assign o_done       = r_q.done;
  assign o_len        = r_q.len;
  assign o_cyc        = r_q.cyc;
  assign o_xdata_req  = r_q.xreq;
  assign o_xdata_wr   = r_q.xwr;
  assign o_xdata_wide = r_q.xwide;
  assign o_xdata_tgt  = r_q.xtgt;
  assign o_result     = r_q.res;
  assign o_flags      = r_q.fl;

endmodule : ictm_core

//--- core/ictm_pkg.sv
// Package: instruction classes, opcode fields and cycle counts for the decoder
package ictm_pkg;

  localparam int unsigned CLK_HZ   = 20000000;
  localparam int unsigned OPC_W    = 8;
  localparam int unsigned CNT_W    = 4;
  localparam logic [3:0]  LEN_1    = 4'h1;
  localparam logic [3:0]  LEN_2    = 4'h2;
  localparam logic [3:0]  LEN_3    = 4'h3;
  localparam logic [3:0]  CYC_4    = 4'h4;
  localparam logic [3:0]  CYC_8    = 4'h8;
  // Opcode groups: high nibble selects operation, low nibble the mode
  localparam logic [3:0]  HI_ADD   = 4'h2;
  localparam logic [3:0]  HI_ADDC  = 4'h3;
  localparam logic [3:0]  HI_ORL   = 4'h4;
  localparam logic [3:0]  HI_ANL   = 4'h5;
  localparam logic [3:0]  HI_XRL   = 4'h6;
  localparam logic [3:0]  HI_SUBB  = 4'h9;
  localparam logic [3:0]  LO_DIRA  = 4'h2;
  localparam logic [3:0]  LO_DIRI  = 4'h3;
  localparam logic [3:0]  LO_IMM   = 4'h4;
  localparam logic [3:0]  LO_DIR   = 4'h5;
  localparam logic [3:0]  LO_IND   = 4'h6;
  localparam logic [3:0]  LO_REG   = 4'h8;
  localparam logic [7:0]  OP_CLR_A = 8'hE4;
  localparam logic [7:0]  OP_CPL_A = 8'hF4;
  localparam logic [7:0]  OP_RR_A  = 8'h03;
  localparam logic [7:0]  OP_RRC_A = 8'h13;
  localparam logic [7:0]  OP_RL_A  = 8'h23;
  localparam logic [7:0]  OP_RLC_A = 8'h33;
  localparam logic [7:0]  OP_SWAP  = 8'hC4;
  localparam logic [7:0]  OP_CODE_BYTE_MOVE_D = 8'h93;
  localparam logic [7:0]  OP_CODE_BYTE_MOVE_P = 8'h83;
  localparam logic [7:0]  OP_XR_I0 = 8'hE2;
  localparam logic [7:0]  OP_XR_I1 = 8'hE3;
  localparam logic [7:0]  OP_XR_D  = 8'hE0;
  localparam logic [7:0]  OP_XW_I0 = 8'hF2;
  localparam logic [7:0]  OP_XW_I1 = 8'hF3;
  localparam logic [7:0]  OP_XW_D  = 8'hF0;
  localparam logic [7:0]  OP_LD_DP = 8'h90;
  localparam logic [7:0]  OP_PUSH  = 8'hC0;
  localparam logic [7:0]  OP_POP   = 8'hD0;
  localparam logic [7:0]  OP_MOVDD = 8'h85;
  localparam logic [7:0]  OP_MOV_IA0 = 8'hF6;
  localparam logic [7:0]  OP_MOV_IA1 = 8'hF7;
  localparam logic [4:0]  OP_MOVDR_HI = 5'h11;
  localparam logic [7:0]  OP_XCHD0 = 8'hD6;
  localparam logic [7:0]  OP_XCHD1 = 8'hD7;
  localparam logic [7:0]  OP_MUL   = 8'hA4;
  localparam logic [7:0]  OP_DIV   = 8'h84;
  // Moves whose length is not given by their addressing group
  localparam logic [7:0]  OP_MOV_AIMM  = 8'h74;
  localparam logic [7:0]  OP_MOV_DIMM  = 8'h75;
  localparam logic [7:0]  OP_MOV_IIMM0 = 8'h76;
  localparam logic [7:0]  OP_MOV_IIMM1 = 8'h77;
  localparam logic [7:0]  OP_MOV_DI0   = 8'h86;
  localparam logic [7:0]  OP_MOV_DI1   = 8'h87;
  localparam logic [7:0]  OP_MOV_ID0   = 8'hA6;
  localparam logic [7:0]  OP_MOV_ID1   = 8'hA7;
  localparam logic [7:0]  OP_SPARE     = 8'hA5;
  localparam logic [4:0]  OP_MOVRI_HI  = 5'h0F;
  localparam logic [4:0]  OP_MOVRD_HI  = 5'h15;

  typedef enum logic [1:0] {
    XT_NONE  = 2'b00,
    XT_RAM   = 2'b01,
    XT_FLASH = 2'b10
  } ictm_xtgt_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } ictm_state_e;

  // Decoded timing of one instruction
  typedef struct packed {
    logic [3:0] len;
    logic [3:0] cyc;
    logic       xdata;
    logic       xwrite;
    logic       xwide;
    logic       known;
  } ictm_dec_s;

  // Flag outputs of the arithmetic unit
  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } ictm_flags_s;

endpackage : ictm_pkg

//--- test/ictm_core_sva.sv
// Checker: retire timing, length and data-move routing of the decoder
module ictm_core_sva #(
  parameter int unsigned OPC_W = 8
) (
  input wire logic                  i_sys_clk,   // Clock
  input wire logic                  i_resetn,    // Reset, active low
  input wire logic                  i_issue,     // Opcode valid
  input wire logic [OPC_W-1:0]      i_opcode,    // First byte
  input wire logic [7:0]            i_acc,       // Accumulator
  input wire logic [7:0]            i_opnd,      // Operand
  input wire logic                  i_cy,        // Carry in
  input wire logic                  i_pswe,      // Store write enable
  input wire logic                  o_ready,     // Idle
  input wire logic                  o_done,      // Retire
  input wire logic [3:0]            o_len,       // Bytes
  input wire logic [3:0]            o_cyc,       // Clocks
  input wire logic                  o_xdata_req, // Data move
  input wire logic                  o_xdata_wr,  // Write
  input wire logic                  o_xdata_wide,// Wide pointer
  input wire logic [1:0]            o_xdata_tgt, // Target
  input wire logic [7:0]            o_result,    // Result
  input wire ictm_pkg::ictm_flags_s o_flags      // Flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [8:0] sum_q;
  logic [8:0] sum_d;
  always_comb begin
    cnt_d = (cnt_q != 4'hF) ? cnt_q + 4'h1 : cnt_q;
    sum_d = sum_q;
    if (i_issue && o_ready) begin
      cnt_d = 4'h1;
      sum_d = {1'b0, i_acc} + {1'b0, i_opnd};
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 4'h0;
      sum_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
      sum_q <= sum_d;
    end
  end
  sequence s_take;
    i_issue && o_ready;
  endsequence
  sequence s_three;
    !o_done ##1 !o_done ##1 o_done;
  endsequence
  a_done_count: assert property (o_done |-> cnt_q == o_cyc)
    else $error("retire clock count differs from cycle figure");
  a_three_cycle: assert property (
    s_take ##1 (o_cyc == 4'h3) |-> s_three)
    else $error("three cycle instruction retired at wrong time");
  a_ready_drop: assert property (
    s_take |=> (o_cyc == 4'h1) || !o_ready)
    else $error("ready stayed high for a multi cycle instruction");
  a_done_single: assert property (o_done && !i_issue |=> !o_done)
    else $error("retire pulse longer than one cycle");
  a_move_shape: assert property (
    o_xdata_req |-> o_len == 4'h1 && o_cyc == 4'h3)
    else $error("data move not one byte and three cycles");
  a_onchip_only: assert property (
    o_xdata_req |-> o_xdata_tgt == ictm_pkg::XT_RAM
                    || o_xdata_tgt == ictm_pkg::XT_FLASH)
    else $error("data move has no on-chip target");
  a_ram_gate: assert property (
    s_take ##0 !i_pswe |=> !o_xdata_req
                           || o_xdata_tgt == ictm_pkg::XT_RAM)
    else $error("data move left ram with store write disabled");
  a_flash_write: assert property (
    s_take ##0 (i_pswe && i_opcode == ictm_pkg::OP_XW_D)
    |=> o_xdata_req && o_xdata_wr && o_xdata_tgt == ictm_pkg::XT_FLASH)
    else $error("enabled store write did not reach flash");
  a_reg_add: assert property (
    s_take ##0 (i_opcode[7:4] == ictm_pkg::HI_ADD && i_opcode[3])
    |=> o_done && o_len == 4'h1 && o_cyc == 4'h1)
    else $error("register add not one byte one cycle");
  a_add_sum: assert property (
    s_take ##0 (i_opcode == 8'h24) |=> {o_flags.cy, o_result} == sum_q)
    else $error("immediate add sum or carry wrong");
endmodule : ictm_core_sva

//--- test/ictm_mem_model.sv
// Partner: on-chip data RAM and flash store, counts accesses per target
module ictm_mem_model (
  input  wire logic       i_sys_clk,  // Clock
  input  wire logic       i_resetn,   // Reset, active low
  input  wire logic       i_req,      // Access strobe
  input  wire logic       i_wr,       // Write
  input  wire logic [1:0] i_tgt,      // Target
  output int              o_ram_rd,   // RAM reads
  output int              o_ram_wr,   // RAM writes
  output int              o_flash_wr, // Flash writes
  output int              o_bad       // Off-chip or flash read
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ram_rd <= 0;
      o_ram_wr <= 0;
      o_flash_wr <= 0;
      o_bad <= 0;
    end else if (i_req) begin
      if (i_tgt == 2'h1 && i_wr) o_ram_wr <= o_ram_wr + 1;
      else if (i_tgt == 2'h1) o_ram_rd <= o_ram_rd + 1;
      else if (i_tgt == 2'h2 && i_wr) o_flash_wr <= o_flash_wr + 1;
      else o_bad <= o_bad + 1;
    end
  end
endmodule : ictm_mem_model

//--- test/tb.sv
// Testbench: timing table of every decoded group, routing and flags
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0]  len;
    logic [3:0]  cyc;
    logic        ar;
    logic [10:0] fr;
  } ictm_note_s;
  logic sys_clk = 1'b0, resetn = 1'b0, iss = 1'b0, cy = 1'b0, pswe = 1'b0;
  logic [7:0] opcode = 8'h00, acc = 8'h00, opnd = 8'h00, result, lf = 8'h0F;
  logic ready, done, xreq, xwr, xwide;
  logic [3:0] len, cyc;
  logic [1:0] xtgt;
  ictm_pkg::ictm_flags_s flags;
  int miscompares = 0, check_count = 0, ram_rd, ram_wr, flash_wr, bad;
  ictm_note_s nq[$];
  logic [3:0] xq[$];
  logic [15:0] tbl [53] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422,
    16'h3811, 16'h3522, 16'h3612, 16'h3422, 16'h9811, 16'h9522, 16'h9612,
    16'h9422, 16'h4333, 16'h5333, 16'h6333, 16'h4222, 16'h5222, 16'h6222,
    16'h5612, 16'h4612, 16'h6612, 16'hE411, 16'hF411, 16'h0311, 16'h1311,
    16'h2311, 16'h3311, 16'hC411, 16'h9313, 16'h8313, 16'hE213, 16'hE313,
    16'hE013, 16'hF213, 16'hF313, 16'hF013, 16'h9033, 16'hC022, 16'hD022,
    16'h8533, 16'hF612, 16'hF712, 16'h8822, 16'hD612, 16'hA414, 16'h8418,
    16'h7422, 16'h7533, 16'h8622, 16'hA622, 16'h7822, 16'hA822, 16'hA511};
  ictm_core uut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_issue(iss),
    .i_opcode(opcode), .i_acc(acc), .i_opnd(opnd), .i_cy(cy), .i_pswe(pswe),
    .o_ready(ready), .o_done(done), .o_len(len), .o_cyc(cyc),
    .o_xdata_req(xreq), .o_xdata_wr(xwr), .o_xdata_wide(xwide),
    .o_xdata_tgt(xtgt), .o_result(result), .o_flags(flags));
  ictm_mem_model u_mem (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_req(xreq),
    .i_wr(xwr), .i_tgt(xtgt), .o_ram_rd(ram_rd), .o_ram_wr(ram_wr),
    .o_flash_wr(flash_wr), .o_bad(bad));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  function automatic logic [10:0] arith(logic [3:0] h, logic [7:0] a,
                                        logic [7:0] b, logic c);
    logic ci;
    logic [8:0] s;
    logic [4:0] l;
    ci = (h == 4'h2) ? 1'b0 : c;
    if (h == 4'h9) begin
      s = {1'b0, a} - {1'b0, b} - ci;
      l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci;
      return {s[8], l[4], (a[7] ^ b[7]) & (a[7] ^ s[7]), s[7:0]};
    end
    s = {1'b0, a} + {1'b0, b} + ci;
    l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
    return {s[8], l[4], ~(a[7] ^ b[7]) & (a[7] ^ s[7]), s[7:0]};
  endfunction : arith
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic do_op(logic [15:0] e, logic p);
    ictm_note_s n;
    logic [7:0] a, b;
    logic r;
    int k;
    lf = lfsr_next(lf);
    a = lf;
    lf = lfsr_next(lf);
    b = lf;
    n.len = e[7:4];
    n.cyc = e[3:0];
    n.ar = (e[15:12] inside {4'h2, 4'h3, 4'h9}) && (e[11:8] >= 4'h4);
    n.fr = arith(e[15:12], a, b, lf[0]);
    iss <= 1'b1;
    opcode <= e[15:8];
    acc <= a;
    opnd <= b;
    cy <= lf[0];
    pswe <= p;
    nq.push_back(n);
    if (e[15:13] == 3'h7 && e[11:8] inside {4'h0, 4'h2, 4'h3})
      xq.push_back({e[12], e[11:8] == 4'h0, (e[12] && p) ? 2'h2 : 2'h1});
    k = 0;
    do begin
      @(negedge sys_clk);
      r = ready;
      @(posedge sys_clk);
      k++;
    end while (r !== 1'b1 && k < 20);
  endtask : do_op
  always @(negedge sys_clk) begin : mon
    ictm_note_s n;
    if (done === 1'b1) begin
      if (nq.size() == 0) chk("spare retire", 16'h0, 16'h1);
      else begin
        n = nq.pop_front();
        chk("length", n.len, len);
        chk("cycles", n.cyc, cyc);
        if (n.ar) chk("flags", n.fr, {flags, result});
      end
    end
    if (xreq === 1'b1) begin
      if (xq.size() == 0) chk("spare move", 16'h0, 16'h1);
      else chk("move", xq.pop_front(), {xwr, xwide, xtgt});
    end
  end
  task close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int p = 0; p < 2; p++) begin
      foreach (tbl[i]) do_op(tbl[i], p[0]);
    end
    iss <= 1'b0;
    repeat (12) @(posedge sys_clk);
    chk("pending", 16'h0, 16'(nq.size() + xq.size()));
    chk("flash writes", 16'h3, 16'(flash_wr));
    chk("ram writes", 16'h3, 16'(ram_wr));
    chk("ram reads", 16'h6, 16'(ram_rd));
    chk("off chip", 16'h0, 16'(bad));
    // Reset in mid-divide: the cut instruction must never retire
    iss <= 1'b1;
    opcode <= ictm_pkg::OP_DIV;
    @(posedge sys_clk);
    iss <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b0;
    @(negedge sys_clk);
    chk("reset state", 16'h2000,
        16'({ready, done, len, cyc, xreq, flags}));
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    do_op(16'h2811, 1'b0);
    iss <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("pending after reset", 16'h0, 16'(nq.size()));
    close_out;
  end
endmodule : tb
bind ictm_core ictm_core_sva #(.OPC_W(OPC_W)) u_sva (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_issue(i_issue), .i_opcode(i_opcode),
  .i_acc(i_acc), .i_opnd(i_opnd), .i_cy(i_cy), .i_pswe(i_pswe),
  .o_ready(o_ready), .o_done(o_done), .o_len(o_len), .o_cyc(o_cyc),
  .o_xdata_req(o_xdata_req), .o_xdata_wr(o_xdata_wr),
  .o_xdata_wide(o_xdata_wide), .o_xdata_tgt(o_xdata_tgt),
  .o_result(o_result), .o_flags(o_flags));
